// [core/cscr_pkg.sv]
// Functional notes
// - boot pin is boot CE; may be WE/OE
// - pin zero WE/OE only; reset pairs boot OE
// - pins one-five may be CE, WE, OE
// - pins six-eleven WE or OE only
// - registers 32-bit; unimplemented bits read zero
// - CE-capable pins get base and option register
// - boot pin has extra sub-block register pair
// - non-CE pins get only option register
// - registers reachable at supervisor level only
// - base registers share one field layout
// - boot base follows exception prefix on first edge after reset release
// - other base registers reset to zero
// - base field bits 12-31, rest reserved
// - pin role field selects CE/WE/OE/alternate
// - alternate pins pick address line or port
package cscr_pkg;
  // ==========================================================
  // sizes
  localparam int OPT_N = 14;
  localparam int BASE_N = 7;
  localparam int PIN_N = 13;
  localparam int ALT_N = 12;
  localparam int OPT_BOOT = 12;
  localparam int OPT_SUB = 13;
  localparam int BASE_BOOT = 5;
  // ==========================================================
  // address map (byte addresses as printed)
  localparam logic [31:0] MAP_LO = 32'h8007_fd00;
  localparam logic [31:0] MAP_HI = 32'h8007_fdfc;
  // index 0..11 select pins, 12 boot, 13 boot sub-block
  localparam logic [31:0] OPT_ADDR [OPT_N] = '{
    32'h8007_fdec, 32'h8007_fde4, 32'h8007_fddc, 32'h8007_fdd4,
    32'h8007_fdcc, 32'h8007_fdc4, 32'h8007_fdbc, 32'h8007_fdb4,
    32'h8007_fdac, 32'h8007_fda4, 32'h8007_fd9c, 32'h8007_fd94,
    32'h8007_fdfc, 32'h8007_fdf4};
  // index 0..4 pins one-five, 5 boot, 6 boot sub-block
  localparam logic [31:0] BASE_ADDR [BASE_N] = '{
    32'h8007_fde0, 32'h8007_fdd8, 32'h8007_fdd0, 32'h8007_fdc8,
    32'h8007_fdc0, 32'h8007_fdf8, 32'h8007_fdf0};
  localparam logic [31:0] ASSIGN_ADDR = 32'h8007_fd80;
  localparam logic [31:0] STATUS_ADDR = 32'h8007_fd84;
  // ==========================================================
  // fields and reset values
  localparam int BA_LSB = 12;
  localparam int BA_W = 20;
  localparam logic [31:0] BASE_MASK = 32'hffff_f000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [BA_W-1:0] BOOT_BA_IP1 = 20'hfff00;
  localparam logic [BA_W-1:0] BOOT_BA_IP0 = 20'h00000;
  localparam logic [31:0] OPT_MASK = 32'hff87_ffef;
  localparam logic [31:0] OPT_RST = 32'h0000_0000;
  localparam int PIN_ROLE_FIELD_LSB = 11;
  localparam logic [31:0] ASSIGN_MASK = 32'h0fff_0fff;
  localparam logic [31:0] ASSIGN_RST = 32'h0000_0000;
  localparam int PORTD_LSB = 16;
  localparam int ST_IP = 0;
  localparam int ST_INIT = 1;
  localparam int ST_CE_LSB = 16;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PIN_ROLE_FIELD_CE = 2'h0,
    PIN_ROLE_FIELD_WE = 2'h1,
    PIN_ROLE_FIELD_OE = 2'h2,
    PIN_ROLE_FIELD_ALT = 2'h3
  } cscr_pin_role_field_e;
  typedef enum logic [5:0] {
    ROLE_CE = 6'h01,
    ROLE_WE = 6'h02,
    ROLE_OE = 6'h04,
    ROLE_BOOT_OE = 6'h08,
    ROLE_ADDR = 6'h10,
    ROLE_PORT = 6'h20
  } cscr_role_e;
endpackage

// [core/cscr_if.sv]
`timescale 1ns/1ns
// register access between the bus slave and the register bank
interface cscr_acc_if;
  logic wr_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic mapped;
  modport slave (output wr_en, addr, wdata, wmask, input rdata, mapped);
  modport regs (input wr_en, addr, wdata, wmask, output rdata, mapped);
endinterface // cscr_acc_if

// pin role fields in, decoded roles out
interface cscr_role_if;
  import cscr_pkg::*;
  logic [1:0] pin_role_field [PIN_N];
  logic [ALT_N-1:0] port_sel;
  cscr_role_e role [PIN_N];
  modport regs (output pin_role_field, port_sel, input role);
  modport dec (input pin_role_field, port_sel, output role);
endinterface // cscr_role_if

// [core/cscr_apb_slave.sv]
`timescale 1ns/1ns
module cscr_apb_slave
  import cscr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [2:0] i_pprot,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  cscr_acc_if.slave acc
);
  logic [31:0] rdata_q;
  logic err_q;
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire priv = i_pprot[0];
  wire refuse = ~priv | ~acc.mapped;

  assign acc.addr = i_paddr;
  assign acc.wdata = i_pwdata;
  assign acc.wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  // commit only at the completing edge, never when refused
  assign acc.wr_en = access & i_pwrite & ~err_q;
  assign o_pready = access;
  assign o_prdata = rdata_q;
  assign o_pslverr = access & err_q;

  // answer prepared in setup so read data leaves a flop
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= refuse;
      rdata_q <= (refuse || i_pwrite) ? 32'h0000_0000 : acc.rdata;
    end
  end
endmodule // cscr_apb_slave

// [core/cscr_role_map.sv]
`timescale 1ns/1ns
module cscr_role_map
  import cscr_pkg::*;
(
  cscr_role_if.dec rif
);
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    localparam bit CE_OK = (i >= 1 && i <= 5) || (i == OPT_BOOT);
    localparam bit IS_BOOT = (i == OPT_BOOT);
    cscr_role_e ce_role;
    cscr_role_e alt_role;
    // pin zero in select mode pairs as the boot output enable
    assign ce_role = CE_OK ? ROLE_CE : ((i == 0) ? ROLE_BOOT_OE : ROLE_OE);
    if (IS_BOOT) begin : g_boot
      // boot pin has no alternate function, stays a chip enable
      assign alt_role = ROLE_CE;
    end else begin : g_alt
      assign alt_role = rif.port_sel[i] ? ROLE_PORT : ROLE_ADDR;
    end
    always_comb begin
      case (rif.pin_role_field[i])
        PIN_ROLE_FIELD_CE: rif.role[i] = ce_role;
        PIN_ROLE_FIELD_WE: rif.role[i] = ROLE_WE;
        PIN_ROLE_FIELD_OE: rif.role[i] = ROLE_OE;
        PIN_ROLE_FIELD_ALT: rif.role[i] = alt_role;
        default: rif.role[i] = ce_role;
      endcase
    end
  end
endmodule // cscr_role_map

// [core/cscr_top.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module cscr_top
  import cscr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [2:0] i_pprot,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // exception prefix level, sampled once after reset
  input wire logic i_exc_prefix,
  // decoded pin roles, index 0..11 select pins, 12 boot pin
  output logic [PIN_N-1:0][5:0] o_pin_role,
  output logic [7:0] o_port_a,
  output logic [3:0] o_port_b,
  // base fields, index 0..4 pins one-five, 5 boot, 6 sub-block
  output logic [BASE_N-1:0][BA_W-1:0] o_base_ba
);

  // ==========================================================
  // bus slave
  cscr_acc_if acc ();
  cscr_role_if rif ();

  cscr_apb_slave u_apb (
    .i_clk_sys (i_clk_sys),
    .i_rstn (i_rstn),
    .i_psel (i_psel),
    .i_penable (i_penable),
    .i_pwrite (i_pwrite),
    .i_paddr (i_paddr),
    .i_pwdata (i_pwdata),
    .i_pstrb (i_pstrb),
    .i_pprot (i_pprot),
    .o_prdata (o_prdata),
    .o_pready (o_pready),
    .o_pslverr (o_pslverr),
    .acc (acc.slave)
  );

  // ==========================================================
  // address decode
  logic [OPT_N-1:0] opt_hit;
  logic [BASE_N-1:0] base_hit;
  wire assign_hit = (acc.addr == ASSIGN_ADDR);
  wire status_hit = (acc.addr == STATUS_ADDR);
  // reserved holes inside the block window still answer, with zero
  wire in_window = (acc.addr >= MAP_LO) && (acc.addr <= MAP_HI);
  wire word_ok = (acc.addr[1:0] == 2'b00);
  assign acc.mapped = in_window & word_ok;

  for (genvar i = 0; i < OPT_N; i++) begin : g_opt_hit
    assign opt_hit[i] = (acc.addr == OPT_ADDR[i]);
  end
  for (genvar i = 0; i < BASE_N; i++) begin : g_base_hit
    assign base_hit[i] = (acc.addr == BASE_ADDR[i]);
  end

  // ==========================================================
  // boot base load from the exception prefix
  // the prefix is a plain port, so it cannot feed the async reset
  // value; it is taken on the first edge after release instead
  logic init_done_q;
  logic ip_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      init_done_q <= 1'b0;
      ip_q <= 1'b0;
    end else if (!init_done_q) begin
      init_done_q <= 1'b1;
      ip_q <= i_exc_prefix;
    end
  end

  wire boot_load = ~init_done_q;
  wire [31:0] boot_init_val =
    {(i_exc_prefix ? BOOT_BA_IP1 : BOOT_BA_IP0), {BA_LSB{1'b0}}};

  // ==========================================================
  // base address registers
  // only the twenty base bits exist, the low bits read zero
  logic [31:0] base_q [BASE_N];
  logic [31:0] base_wr [BASE_N];

  for (genvar i = 0; i < BASE_N; i++) begin : g_base
    // one layout for every base register
    assign base_wr[i] =
      ((base_q[i] & ~acc.wmask) | (acc.wdata & acc.wmask)) & BASE_MASK;
    if (i == BASE_BOOT) begin : g_boot
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          base_q[i] <= BASE_RST;
        end else if (boot_load) begin
          base_q[i] <= boot_init_val;
        end else if (acc.wr_en && base_hit[i]) begin
          base_q[i] <= base_wr[i];
        end
      end
    end else begin : g_plain
      // pins one-five and the boot sub-block reset to zero
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          base_q[i] <= BASE_RST;
        end else if (acc.wr_en && base_hit[i]) begin
          base_q[i] <= base_wr[i];
        end
      end
    end
    assign o_base_ba[i] = base_q[i][BA_LSB +: BA_W];
  end

  // ==========================================================
  // option registers
  // every pin has one; the boot pin has a second for its sub-block
  logic [31:0] opt_q [OPT_N];
  logic [31:0] opt_wr [OPT_N];

  for (genvar i = 0; i < OPT_N; i++) begin : g_opt
    assign opt_wr[i] =
      ((opt_q[i] & ~acc.wmask) | (acc.wdata & acc.wmask)) & OPT_MASK;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
        opt_q[i] <= OPT_RST;
      end else if (acc.wr_en && opt_hit[i]) begin
        opt_q[i] <= opt_wr[i];
      end
    end
  end

  // ==========================================================
  // alternate function assignment
  // low twelve bits pick port (1) or address line (0) per pin,
  // bits 16..27 are the port output levels
  logic [31:0] assign_q;
  wire [31:0] assign_wr =
    ((assign_q & ~acc.wmask) | (acc.wdata & acc.wmask)) & ASSIGN_MASK;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      assign_q <= ASSIGN_RST;
    end else if (acc.wr_en && assign_hit) begin
      assign_q <= assign_wr;
    end
  end

  // ==========================================================
  // pin role decode
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin_role_field
    assign rif.pin_role_field[i] = opt_q[i][PIN_ROLE_FIELD_LSB +: 2];
  end
  assign rif.port_sel = assign_q[ALT_N-1:0];

  cscr_role_map u_role (
    .rif (rif.dec)
  );

  // roles leave through flops so pins never see decode glitches;
  // the cost is one cycle between a write and the new role
  cscr_role_e role_q [PIN_N];
  logic [PIN_N-1:0] ce_act;

  for (genvar i = 0; i < PIN_N; i++) begin : g_role
    // pins six-eleven must never show a chip enable, not even in reset
    localparam cscr_role_e ROLE_RST = (i == 0) ? ROLE_BOOT_OE :
      ((i > 5 && i < OPT_BOOT) ? ROLE_OE : ROLE_CE);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
        role_q[i] <= ROLE_RST;
      end else begin
        role_q[i] <= rif.role[i];
      end
    end
    assign o_pin_role[i] = role_q[i];
    assign ce_act[i] = (role_q[i] == ROLE_CE);
  end

  // port levels, only meaningful on pins in port mode
  logic [ALT_N-1:0] port_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      port_q <= '0;
    end else begin
      port_q <= assign_q[PORTD_LSB +: ALT_N];
    end
  end

  assign o_port_a = port_q[7:0];
  assign o_port_b = port_q[11:8];

  // ==========================================================
  // status: captured prefix, init done, live chip enables
  wire [31:0] status_val = {
    {(16 - PIN_N){1'b0}},
    ce_act,
    14'h0000,
    init_done_q,
    ip_q
  };

  // ==========================================================
  // read mux
  // hits are one-hot, so an or of gated words is enough
  logic [31:0] opt_rd [OPT_N];
  logic [31:0] base_rd [BASE_N];

  for (genvar i = 0; i < OPT_N; i++) begin : g_opt_rd
    if (i == 0) begin : g_first
      assign opt_rd[i] = opt_hit[i] ? opt_q[i] : 32'h0000_0000;
    end else begin : g_next
      assign opt_rd[i] = opt_rd[i-1] | (opt_hit[i] ? opt_q[i] : 32'h0000_0000);
    end
  end

  for (genvar i = 0; i < BASE_N; i++) begin : g_base_rd
    if (i == 0) begin : g_first
      assign base_rd[i] = base_hit[i] ? base_q[i] : 32'h0000_0000;
    end else begin : g_next
      assign base_rd[i] = base_rd[i-1] | (base_hit[i] ? base_q[i] : 32'h0000_0000);
    end
  end

  wire [31:0] aux_rd =
    (assign_hit ? assign_q : 32'h0000_0000) |
    (status_hit ? status_val : 32'h0000_0000);

  // unmatched addresses inside the window fall through to zero
  assign acc.rdata = opt_rd[OPT_N-1] | base_rd[BASE_N-1] | aux_rd;

endmodule // cscr_top

// [dv/cscr_mem_model.sv]
`timescale 1ns/1ns
module cscr_mem_model
  import cscr_pkg::*;
(
  input wire logic [PIN_N-1:0][5:0] i_pin_role,
  output logic [3:0] o_ce_cnt
);
  // ==========================================================
  // external memories: one device behind every pin that acts as its chip enable
  always_comb begin
    o_ce_cnt = 4'h0;
    for (int i = 0; i < PIN_N; i++) begin
      o_ce_cnt = o_ce_cnt + {3'h0, i_pin_role[i][0]};
    end
  end
endmodule // cscr_mem_model

// [dv/cscr_properties.sv]
`timescale 1ns/1ns
module cscr_checker
  import cscr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [2:0] i_pprot,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_exc_prefix,
  input wire logic [PIN_N-1:0][5:0] o_pin_role,
  input wire logic [7:0] o_port_a,
  input wire logic [3:0] o_port_b,
  input wire logic [BASE_N-1:0][BA_W-1:0] o_base_ba
);
  // ==========================================================
  // helpers
  // role decode settles one edge after reset release
  logic [1:0] rel_q;
  logic hi_bad;
  logic lo_bad;
  wire acc = i_psel && i_penable;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rel_q <= 2'h0;
    end else if (rel_q != 2'h2) begin
      rel_q <= rel_q + 2'h1;
    end
  end
  always_comb begin
    hi_bad = 1'b0;
    lo_bad = 1'b0;
    for (int i = 6; i < 12; i++) begin
      hi_bad = hi_bad | o_pin_role[i][0] | o_pin_role[i][3];
    end
    for (int i = 1; i < 6; i++) begin
      lo_bad = lo_bad | o_pin_role[i][3];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_user_refused: assert property (acc && !i_pprot[0] |-> o_pslverr && o_prdata == 32'h0)
    else $error("user access not refused");
  a_refused_hold: assert property (acc && i_pwrite && !i_pprot[0] |=> $stable(o_base_ba))
    else $error("refused write changed a base");
  a_super_taken: assert property (acc && i_pprot[0] && (i_paddr inside {BASE_ADDR}) |-> !o_pslverr)
    else $error("supervisor access refused");
  a_base_unimpl: assert property (acc && !i_pwrite && (i_paddr inside {BASE_ADDR})
    |-> (o_prdata & ~BASE_MASK) == 32'h0)
    else $error("base reserved bits not zero");
  a_opt_unimpl: assert property (acc && !i_pwrite && (i_paddr inside {OPT_ADDR})
    |-> (o_prdata & ~OPT_MASK) == 32'h0)
    else $error("option unimplemented bits not zero");
  a_boot_load: assert property (rel_q == 2'h1 |->
    o_base_ba[BASE_BOOT] == ($past(i_exc_prefix) ? BOOT_BA_IP1 : BOOT_BA_IP0))
    else $error("boot base reset value wrong");
  a_base_clear: assert property (rel_q == 2'h1 |-> o_base_ba[4:0] == '0 && o_base_ba[6] == '0)
    else $error("base reset value not zero");
  a_pin0_never_ce: assert property (rel_q != 2'h0 |-> !o_pin_role[0][0])
    else $error("pin zero acting as chip enable");
  a_low_roles: assert property (rel_q != 2'h0 |-> !lo_bad)
    else $error("pins one to five given boot role");
  a_high_no_ce: assert property (rel_q != 2'h0 |-> !hi_bad)
    else $error("pins six to eleven acting as chip enable");
  a_boot_role: assert property (rel_q != 2'h0 |-> o_pin_role[12] inside {6'h01, 6'h02, 6'h04})
    else $error("boot pin role illegal");
endmodule // cscr_checker

bind cscr_top cscr_checker u_chk (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .i_pstrb, .i_pprot, .o_prdata, .o_pready, .o_pslverr,
  .i_exc_prefix, .o_pin_role, .o_port_a, .o_port_b, .o_base_ba);

// [dv/cscr_bench.sv]
`timescale 1ns/1ns
module cscr_bench;
  import cscr_pkg::*;
  logic i_clk_sys, i_rstn, i_psel, i_penable, i_pwrite, i_exc_prefix, o_pready, o_pslverr, er;
  logic [31:0] i_paddr, i_pwdata, o_prdata, rd;
  logic [3:0] i_pstrb, o_port_b, ce_cnt;
  logic [2:0] i_pprot;
  logic [7:0] o_port_a;
  logic [PIN_N-1:0][5:0] o_pin_role;
  logic [BASE_N-1:0][BA_W-1:0] o_base_ba;
  int fail_count = 0;
  int check_count = 0;
  cscr_top DUT (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .i_pprot, .o_prdata, .o_pready, .o_pslverr, .i_exc_prefix, .o_pin_role,
    .o_port_a, .o_port_b, .o_base_ba);
  cscr_mem_model u_mem (.i_pin_role(o_pin_role), .o_ce_cnt(ce_cnt));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic s);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pprot <= {2'h0, s};
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rst(input logic p);
    i_rstn <= 1'b0;
    i_exc_prefix <= p;
    repeat (10) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask
  function automatic logic [5:0] exp_role(int p, int c, logic port);
    if (c == 3) return (p == 12) ? 6'h01 : (port ? 6'h20 : 6'h10);
    if (c != 0) return 6'h01 << c;
    return (p == 0) ? 6'h08 : (p > 5 && p < 12) ? 6'h04 : 6'h01;
  endfunction
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, tests
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    i_rstn = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 32'h0;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    i_pprot = 3'h1;
    i_exc_prefix = 1'b0;
    rst(1'b1);
    apb(1'b0, BASE_ADDR[BASE_BOOT], 32'h0, 1'b1);
    chk(rd, 32'hfff0_0000);
    chk({28'h0, ce_cnt}, 32'h6);
    apb(1'b0, STATUS_ADDR, 32'h0, 1'b1);
    chk(rd, 32'h103e_0003);
    rst(1'b0);
    for (int i = 0; i < BASE_N; i++) begin
      apb(1'b0, BASE_ADDR[i], 32'h0, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, BASE_ADDR[i], 32'hffff_ffff, 1'b1);
      apb(1'b0, BASE_ADDR[i], 32'h0, 1'b1);
      chk(rd, BASE_MASK);
      chk({12'h0, o_base_ba[i]}, 32'h000f_ffff);
    end
    apb(1'b1, BASE_ADDR[6], 32'h0, 1'b1);
    apb(1'b0, BASE_ADDR[BASE_BOOT], 32'h0, 1'b1);
    chk(rd, BASE_MASK);
    for (int i = 0; i < OPT_N; i++) begin
      apb(1'b1, OPT_ADDR[i], 32'hffff_ffff, 1'b1);
      apb(1'b0, OPT_ADDR[i], 32'h0, 1'b1);
      chk(rd, OPT_MASK);
    end
    apb(1'b1, 32'h8007_fde8, 32'hffff_ffff, 1'b1);
    apb(1'b0, 32'h8007_fde8, 32'h0, 1'b1);
    chk({rd[31:1], rd[0] | er}, 32'h0);
    apb(1'b0, 32'h8007_fc00, 32'h0, 1'b1);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, BASE_ADDR[0], 32'h0, 1'b0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, BASE_ADDR[0], 32'h0, 1'b0);
    chk(rd, 32'h0);
    apb(1'b0, BASE_ADDR[0], 32'h0, 1'b1);
    chk(rd, BASE_MASK);
    apb(1'b1, ASSIGN_ADDR, 32'hffff_ffff, 1'b1);
    apb(1'b0, ASSIGN_ADDR, 32'h0, 1'b1);
    chk(rd, ASSIGN_MASK);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ASSIGN_ADDR, (s == 1) ? 32'h0abc_0fff : 32'h0, 1'b1);
      for (int p = 0; p < PIN_N; p++) begin
        for (int c = 0; c < 4; c++) begin
          apb(1'b1, OPT_ADDR[p], 32'(c) << PIN_ROLE_FIELD_LSB, 1'b1);
          @(posedge i_clk_sys);
          chk({26'h0, o_pin_role[p]}, {26'h0, exp_role(p, c, s == 1)});
        end
      end
    end
    chk({20'h0, o_port_b, o_port_a}, 32'h0000_0abc);
    stop_test();
  end
endmodule // cscr_bench
